/* File: rtl/uil_defines.svh */
`ifndef UIL_DEFINES_SVH
`define UIL_DEFINES_SVH

// clock and line timing
`define UIL_CLK_HZ 50000000
`define UIL_OVS 16
`define UIL_IR_MAX_BPS 115200
`define UIL_IR_MIN_DIV ((`UIL_CLK_HZ + `UIL_OVS * `UIL_IR_MAX_BPS - 1) / (`UIL_OVS * `UIL_IR_MAX_BPS))
`define UIL_LP_MIN_HZ 1420000
`define UIL_LP_MAX_HZ 2120000
`define UIL_LP_PSC_MIN ((`UIL_CLK_HZ + `UIL_LP_MAX_HZ - 1) / `UIL_LP_MAX_HZ)
`define UIL_LP_PSC_MAX (`UIL_CLK_HZ / `UIL_LP_MIN_HZ)
`define UIL_IR_PULSE_TICKS 4'h3
`define UIL_LP_PULSE_PER 2'h3
`define UIL_GLITCH_PER 2'h2
`define UIL_BRK_BITS 4'hd
`define UIL_DATA_BITS 4'h9
`define UIL_BRK_SHORT 4'ha
`define UIL_BRK_LONG 4'hb
`define UIL_SMP_A 4'h7
`define UIL_SMP_B 4'h8
`define UIL_SMP_C 4'h9
`define UIL_PH_LAST 4'hf

// register offsets
`define UIL_ADR_STATUS 5'h00
`define UIL_ADR_DATA 5'h04
`define UIL_ADR_DIV 5'h08
`define UIL_ADR_CTRL 5'h0c
`define UIL_ADR_PSC 5'h10

// status bits
`define UIL_ST_TC 0
`define UIL_ST_RECEIVE_NOT_EMPTY 1
`define UIL_ST_FE 2
`define UIL_ST_BDF 3
`define UIL_ST_TXE 4
`define UIL_ST_RXB 5
`define UIL_ST_TXB 6
`define UIL_ST_LPOK 7

// reset values
`define UIL_DIV_RST 16'h001c
`define UIL_PSC_RST 8'h00
`define UIL_CTRL_RST 8'h00

`endif

/* File: rtl/uil_pkg.sv */
package uil_pkg;

   typedef struct packed {
      logic bie;   // break_interrupt_enable
      logic bls;   // break_length_select
      logic send_break;   // send_break
      logic infrared_low_power;  // infrared_low_power
      logic infrared_enable;  // infrared_enable
      logic lin;   // lin_enable
      logic ren;   // receiver_enable
      logic transmitter_enable;   // transmitter_enable
   } uil_ctrl_t;

   typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} uil_tx_st_t;
   typedef enum logic [1:0] {RX_IDLE, RX_FRAME, RX_HOLD} uil_rx_st_t;
   typedef enum logic [1:0] {BK_IDLE, BK_BITS, BK_DELIM} uil_bk_st_t;

endpackage : uil_pkg

/* File: rtl/uil_brk_det.sv */
`timescale 1ns/100ps
`include "uil_defines.svh"

module uil_brk_det (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tick_i,
   input wire logic en_i,
   input wire logic rxd_i,
   input wire logic long_i,
   output logic det_o,
   output logic rel_o
);

   uil_pkg::uil_bk_st_t st_q;
   logic [3:0] ph_q;
   logic [1:0] smp_q;
   logic [3:0] zc_q;
   logic [3:0] need;
   logic maj;

   assign need = long_i ? `UIL_BRK_LONG : `UIL_BRK_SHORT;
   assign maj = (smp_q[0] & smp_q[1]) | (smp_q[0] & rxd_i) | (smp_q[1] & rxd_i);

   // own start search and bit timing, apart from the receiver
   always_ff @(posedge clk_i) begin
      det_o <= 1'b0;
      rel_o <= 1'b0;
      if (rst_i || !en_i) begin
         st_q <= uil_pkg::BK_IDLE;
         ph_q <= 4'h0;
         smp_q <= 2'h0;
         zc_q <= 4'h0;
      end else begin
         unique case (st_q)
            uil_pkg::BK_IDLE: begin
               if (tick_i && !rxd_i) begin
                  st_q <= uil_pkg::BK_BITS;
                  ph_q <= 4'h1;
                  zc_q <= 4'h0;
               end
            end
            uil_pkg::BK_BITS: begin
               if (tick_i) begin
                  ph_q <= ph_q + 4'h1;
                  if (ph_q == `UIL_SMP_A || ph_q == `UIL_SMP_B) begin
                     smp_q <= {smp_q[0], rxd_i};
                  end
                  if (ph_q == `UIL_SMP_C) begin
                     if (maj) begin
                        st_q <= uil_pkg::BK_IDLE;
                        rel_o <= 1'b1;
                     end else begin
                        zc_q <= zc_q + 4'h1;
                        if (zc_q + 4'h1 == need) begin
                           st_q <= uil_pkg::BK_DELIM;
                        end
                     end
                  end
               end
            end
            uil_pkg::BK_DELIM: begin
               if (tick_i) begin
                  ph_q <= ph_q + 4'h1;
                  if (ph_q == `UIL_SMP_A || ph_q == `UIL_SMP_B) begin
                     smp_q <= {smp_q[0], rxd_i};
                  end
                  if (ph_q == `UIL_SMP_C && maj) begin
                     st_q <= uil_pkg::BK_IDLE;
                     det_o <= 1'b1;
                     rel_o <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   chk_brk_det_count: assert property (det_o |-> $past(zc_q) == $past(need))
      else $error("break flagged without the required zero count");

   chk_brk_one_abort: assert property ((st_q == uil_pkg::BK_BITS && tick_i
      && ph_q == `UIL_SMP_C && maj && en_i) |=> (st_q == uil_pkg::BK_IDLE && rel_o && !det_o))
      else $error("break search not abandoned on a one");

endmodule : uil_brk_det

/* File: rtl/uil_top.sv */
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/100ps
`include "uil_defines.svh"

module uil_top #(
   parameter int AW = 5
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rx_i,
   input wire logic ir_rx_i,
   output logic tx_o,
   output logic ir_tx_o,
   output logic break_irq_o
);

   uil_pkg::uil_ctrl_t ctrl_q;
   uil_pkg::uil_tx_st_t tx_st_q;
   uil_pkg::uil_rx_st_t rx_st_q;
   logic [15:0] div_q;
   logic [7:0] psc_q;
   logic [15:0] bcnt_q;
   logic tick_q;
   logic req, wr, rd;
   logic [4:0] adr;

   assign adr = wb_adr_i[4:0];
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = req & wb_we_i;
   assign rd = req & ~wb_we_i;

   // transmitter
   logic [13:0] tsh_q;
   logic [3:0] tbits_q;
   logic [3:0] tph_q;
   logic tbrk_q;
   logic [7:0] thold_q;
   logic tfull_q;
   logic tc_q;
   logic start_brk, start_dat, tx_done, bit_start, tx_busy, rx_busy;

   assign start_brk = (tx_st_q == uil_pkg::TX_IDLE) & ctrl_q.transmitter_enable & ctrl_q.send_break;
   assign start_dat = (tx_st_q == uil_pkg::TX_IDLE) & ctrl_q.transmitter_enable & tfull_q & ~ctrl_q.send_break;
   assign tx_done = (tx_st_q == uil_pkg::TX_SHIFT) & tick_q & (tph_q == `UIL_PH_LAST)
      & (tbits_q == 4'h0);
   assign bit_start = start_brk | start_dat
      | ((tx_st_q == uil_pkg::TX_SHIFT) & tick_q & (tph_q == `UIL_PH_LAST));
   assign tx_busy = (tx_st_q == uil_pkg::TX_SHIFT);

   // oversampling tick, sixteen per bit, restarted at frame start so the first bit is full
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bcnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end else if (start_brk || start_dat) begin
         bcnt_q <= (div_q > 16'h0001) ? 16'h0001 : 16'h0000;
         tick_q <= (div_q <= 16'h0001);
      end else if ({1'b0, bcnt_q} + 17'h00001 >= {1'b0, div_q}) begin
         bcnt_q <= 16'h0000;
         tick_q <= 1'b1;
      end else begin
         bcnt_q <= bcnt_q + 16'h0001;
         tick_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_st_q <= uil_pkg::TX_IDLE;
         tsh_q <= 14'h3fff;
         tbits_q <= 4'h0;
         tph_q <= 4'h0;
         tbrk_q <= 1'b0;
      end else begin
         unique case (tx_st_q)
            uil_pkg::TX_IDLE: begin
               tph_q <= 4'h0;
               if (start_brk) begin
                  tsh_q <= {1'b1, 13'h0000};
                  tbits_q <= `UIL_BRK_BITS;
                  tbrk_q <= 1'b1;
                  tx_st_q <= uil_pkg::TX_SHIFT;
               end else if (start_dat) begin
                  tsh_q <= {4'hf, 1'b1, thold_q, 1'b0};
                  tbits_q <= `UIL_DATA_BITS;
                  tbrk_q <= 1'b0;
                  tx_st_q <= uil_pkg::TX_SHIFT;
               end
            end
            uil_pkg::TX_SHIFT: begin
               if (tick_q) begin
                  tph_q <= tph_q + 4'h1;
                  if (tph_q == `UIL_PH_LAST) begin
                     tsh_q <= {1'b1, tsh_q[13:1]};
                     tbits_q <= tbits_q - 4'h1;
                     if (tbits_q == 4'h0) begin
                        tx_st_q <= uil_pkg::TX_IDLE;
                     end
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_o <= 1'b1;
      end else begin
         tx_o <= tx_busy ? tsh_q[0] : 1'b1;
      end
   end

   // holding register and transmission complete, set wins over clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         thold_q <= 8'h00;
         tfull_q <= 1'b0;
         tc_q <= 1'b1;
      end else begin
         if (wr && adr == `UIL_ADR_DATA && wb_sel_i[0]) begin
            thold_q <= wb_dat_i[7:0];
            tfull_q <= 1'b1;
         end else if (start_dat) begin
            tfull_q <= 1'b0;
         end
         if (tx_done && !tfull_q) begin
            tc_q <= 1'b1;
         end else if (wr && adr == `UIL_ADR_DATA && wb_sel_i[0]) begin
            tc_q <= 1'b0;
         end
      end
   end

   // infrared encoder
   logic [7:0] tpc_q;
   logic [1:0] lpn_q;
   logic ir_ok, ir_pulse, lp_ok;

   assign ir_ok = (psc_q != 8'h00) && (div_q >= 16'(`UIL_IR_MIN_DIV));
   assign lp_ok = (psc_q >= 8'(`UIL_LP_PSC_MIN)) && (psc_q <= 8'(`UIL_LP_PSC_MAX));
   assign ir_pulse = tx_busy & ~tsh_q[0]
      & (ctrl_q.infrared_low_power ? (lpn_q < `UIL_LP_PULSE_PER) : (tph_q < `UIL_IR_PULSE_TICKS));

   always_ff @(posedge clk_i) begin
      if (rst_i || bit_start) begin
         tpc_q <= 8'h00;
         lpn_q <= 2'h0;
      end else if (tpc_q + 8'h01 >= psc_q) begin
         tpc_q <= 8'h00;
         lpn_q <= (lpn_q == `UIL_LP_PULSE_PER) ? lpn_q : lpn_q + 2'h1;
      end else begin
         tpc_q <= tpc_q + 8'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ir_tx_o <= 1'b0;
      end else begin
         ir_tx_o <= ctrl_q.infrared_enable & ir_ok & ~rx_busy & ir_pulse;
      end
   end

   // infrared decoder with glitch filter
   logic [7:0] rpc_q;
   logic [1:0] rlow_q;
   logic [4:0] dhold_q;
   logic rxd;

   always_ff @(posedge clk_i) begin
      if (rst_i || ir_rx_i || tx_busy || psc_q == 8'h00) begin
         rpc_q <= 8'h00;
         rlow_q <= 2'h0;
      end else if (rpc_q + 8'h01 >= psc_q) begin
         rpc_q <= 8'h00;
         rlow_q <= (rlow_q == `UIL_GLITCH_PER) ? rlow_q : rlow_q + 2'h1;
      end else begin
         rpc_q <= rpc_q + 8'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dhold_q <= 5'h00;
      end else if (rlow_q == `UIL_GLITCH_PER && !ir_rx_i && !tx_busy) begin
         dhold_q <= 5'h10;
      end else if (tick_q && dhold_q != 5'h00) begin
         dhold_q <= dhold_q - 5'h01;
      end
   end

   assign rxd = ctrl_q.infrared_enable ? (dhold_q == 5'h00) : rx_i;

   // receiver
   logic [3:0] rph_q;
   logic [3:0] rbit_q;
   logic [1:0] rsmp_q;
   logic [7:0] rsh_q;
   logic [7:0] rdat_q;
   logic receive_not_empty_q, fe_q, bdf_q;
   logic maj, rx_stop, brk_det, brk_rel, rd_data;

   assign maj = (rsmp_q[0] & rsmp_q[1]) | (rsmp_q[0] & rxd) | (rsmp_q[1] & rxd);
   assign rx_stop = (rx_st_q == uil_pkg::RX_FRAME) & ctrl_q.ren & tick_q
      & (rph_q == `UIL_SMP_C) & (rbit_q == `UIL_DATA_BITS);
   assign rx_busy = (rx_st_q != uil_pkg::RX_IDLE);
   assign rd_data = rd & (adr == `UIL_ADR_DATA);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_st_q <= uil_pkg::RX_IDLE;
         rph_q <= 4'h0;
         rbit_q <= 4'h0;
         rsmp_q <= 2'h0;
         rsh_q <= 8'h00;
         rdat_q <= 8'h00;
      end else begin
         unique case (rx_st_q)
            uil_pkg::RX_IDLE: begin
               if (ctrl_q.ren && tick_q && !rxd) begin
                  rx_st_q <= uil_pkg::RX_FRAME;
                  rph_q <= 4'h1;
                  rbit_q <= 4'h0;
               end
            end
            uil_pkg::RX_FRAME: begin
               if (!ctrl_q.ren) begin
                  rx_st_q <= uil_pkg::RX_IDLE;
               end else if (tick_q) begin
                  rph_q <= rph_q + 4'h1;
                  if (rph_q == `UIL_PH_LAST) begin
                     rbit_q <= rbit_q + 4'h1;
                  end
                  if (rph_q == `UIL_SMP_A || rph_q == `UIL_SMP_B) begin
                     rsmp_q <= {rsmp_q[0], rxd};
                  end
                  if (rph_q == `UIL_SMP_C) begin
                     if (rbit_q == 4'h0) begin
                        if (maj) begin
                           rx_st_q <= uil_pkg::RX_IDLE;
                        end
                     end else if (rbit_q < `UIL_DATA_BITS) begin
                        rsh_q <= {maj, rsh_q[7:1]};
                     end else begin
                        rdat_q <= rsh_q;
                        rx_st_q <= (!maj && ctrl_q.lin) ? uil_pkg::RX_HOLD
                           : uil_pkg::RX_IDLE;
                     end
                  end
               end
            end
            uil_pkg::RX_HOLD: begin
               if (!ctrl_q.lin || brk_rel) begin
                  rx_st_q <= uil_pkg::RX_IDLE;
               end
            end
         endcase
      end
   end

   uil_brk_det u_brk (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick_q),
      .en_i(ctrl_q.ren),
      .rxd_i(rxd),
      .long_i(ctrl_q.bls),
      .det_o(brk_det),
      .rel_o(brk_rel)
   );

   // status flags, set wins over clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         receive_not_empty_q <= 1'b0;
         fe_q <= 1'b0;
         bdf_q <= 1'b0;
         break_irq_o <= 1'b0;
      end else begin
         if (rx_stop) begin
            receive_not_empty_q <= 1'b1;
         end else if (rd_data) begin
            receive_not_empty_q <= 1'b0;
         end
         if (rx_stop && !maj) begin
            fe_q <= 1'b1;
         end else if (rd_data) begin
            fe_q <= 1'b0;
         end
         if (brk_det && ctrl_q.lin) begin
            bdf_q <= 1'b1;
         end else if (wr && adr == `UIL_ADR_STATUS && wb_sel_i[0] && wb_dat_i[`UIL_ST_BDF]) begin
            bdf_q <= 1'b0;
         end
         break_irq_o <= bdf_q & ctrl_q.bie;
      end
   end

   // register writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= `UIL_CTRL_RST;
         div_q <= `UIL_DIV_RST;
         psc_q <= `UIL_PSC_RST;
      end else begin
         if (wr && adr == `UIL_ADR_CTRL && wb_sel_i[0]) begin
            ctrl_q <= wb_dat_i[7:0];
         end else if (tx_done && tbrk_q) begin
            ctrl_q.send_break <= 1'b0;
         end
         if (wr && adr == `UIL_ADR_DIV && wb_sel_i[0]) begin
            div_q[7:0] <= wb_dat_i[7:0];
         end
         if (wr && adr == `UIL_ADR_DIV && wb_sel_i[1]) begin
            div_q[15:8] <= wb_dat_i[15:8];
         end
         if (wr && adr == `UIL_ADR_PSC && wb_sel_i[0]) begin
            psc_q <= wb_dat_i[7:0];
         end
      end
   end

   // bus answer and read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req;
         if (rd) begin
            unique case (adr)
               `UIL_ADR_STATUS: wb_dat_o <= {24'h000000, lp_ok, tx_busy, rx_busy, ~tfull_q,
                  bdf_q, fe_q, receive_not_empty_q, tc_q};
               `UIL_ADR_DATA: wb_dat_o <= {24'h000000, rdat_q};
               `UIL_ADR_DIV: wb_dat_o <= {16'h0000, div_q};
               `UIL_ADR_CTRL: wb_dat_o <= {24'h000000, ctrl_q};
               `UIL_ADR_PSC: wb_dat_o <= {24'h000000, psc_q};
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence sq_break_low;
      ##1 !tx_o [*8];
   endsequence

   chk_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   chk_ir_idle_low: assert property (!tx_busy |=> !ir_tx_o)
      else $error("infrared output high while idle");
   chk_ir_one_dark: assert property ((tx_busy && tsh_q[0]) |=> !ir_tx_o)
      else $error("pulse sent for a one bit");
   chk_ir_pulse_len: assert property ((ir_tx_o && !$past(ctrl_q.infrared_low_power)) |-> $past(tph_q) < 4'h3)
      else $error("normal infrared pulse too long");
   chk_ir_half_duplex: assert property (rx_busy |=> !ir_tx_o)
      else $error("encoding while receiving");
   chk_ir_psc_zero: assert property ((psc_q == 8'h00) |=> !ir_tx_o)
      else $error("infrared active with prescaler zero");
   chk_brk_line_low: assert property (start_brk |=> sq_break_low)
      else $error("break not driven low");
   chk_bdf_needs_det: assert property ($rose(bdf_q) |-> $past(brk_det) && $past(ctrl_q.lin))
      else $error("break flag without detected delimiter");
   chk_lin_off_nohold: assert property (!ctrl_q.lin |=> rx_st_q != uil_pkg::RX_HOLD)
      else $error("receiver held with lin disabled");

endmodule : uil_top

/* File: verif/uil_line_model.sv */
`timescale 1ns/100ps
module uil_line_model (
   input wire logic clk_i,
   input wire logic tx_i,
   output logic rx_o,
   output logic ir_rx_o
);
   logic dom_q = 1'b0;
   logic ir_q = 1'b1;
   // wired-and bus, recessive high, own frames echo back
   assign rx_o = tx_i & ~dom_q;
   // photodiode side idles high, light pulse gives low
   assign ir_rx_o = ir_q;
   // another node holds the bus dominant for n cycles
   task automatic dominant(input int n);
      dom_q <= 1'b1;
      repeat (n) @(posedge clk_i);
      dom_q <= 1'b0;
   endtask : dominant
   // remote sender: one stop bit, zero bit as low pulse of w cycles
   task automatic ir_send(input logic [7:0] b, input int bc, input int w);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         if (!f[i]) begin
            ir_q <= 1'b0;
            repeat (w) @(posedge clk_i);
            ir_q <= 1'b1;
            repeat (bc - w) @(posedge clk_i);
         end else begin
            repeat (bc) @(posedge clk_i);
         end
      end
   endtask : ir_send
endmodule : uil_line_model

/* File: verif/uil_top_tb.sv */
`timescale 1ns/100ps
module uil_top_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [4:0] adr = 5'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] q;
   logic ack;
   logic rx;
   logic irrx;
   logic tx;
   logic irtx;
   logic irq;
   int err_count = 0;
   int checks_done = 0;
   int ih;
   int tl;

   always #10 clk = ~clk;

   uil_top uut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .rx_i(rx), .ir_rx_i(irrx), .tx_o(tx), .ir_tx_o(irtx), .break_irq_o(irq));
   uil_line_model m (.clk_i(clk), .tx_i(tx), .rx_o(rx), .ir_rx_o(irrx));

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 100);
      q = rdat;
      chk("bus ack", 32'h1, {31'h0, ack});
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask : wb

   task automatic count(input int n);
      ih = 0;
      tl = 0;
      repeat (n) begin
         @(posedge clk);
         ih += (irtx === 1'b1);
         tl += (tx === 1'b0);
      end
   endtask : count

   task automatic t_reset;
      chk("idle ir out", 32'h0, {31'h0, irtx});
      wb(0, 5'h00, 0);
      chk("status reset", 32'h11, q);
      wb(0, 5'h08, 0);
      chk("divider reset", 32'h1c, q);
      wb(0, 5'h14, 0);
      chk("unmapped read", 32'h0, q);
   endtask : t_reset

   task automatic t_nrz;
      logic [9:0] f;
      int n;
      f = {1'b1, 8'ha6, 1'b0};
      n = 0;
      wb(1, 5'h08, 32'h1);
      wb(1, 5'h0c, 32'h03);
      wb(1, 5'h04, 32'ha6);
      while (tx !== 1'b0 && n < 50) begin
         @(posedge clk);
         n++;
      end
      repeat (8) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         chk("line bit", {31'h0, f[i]}, {31'h0, tx});
         repeat (16) @(posedge clk);
      end
      repeat (20) @(posedge clk);
      wb(0, 5'h04, 0);
      chk("echo byte", 32'ha6, q);
   endtask : t_nrz

   task automatic t_ir_tx(input logic [7:0] prescaler_value, input logic [7:0] c, input int e);
      wb(1, 5'h08, 32'h1c);
      wb(1, 5'h10, {24'h0, prescaler_value});
      wb(1, 5'h0c, {24'h0, c});
      wb(1, 5'h04, 32'hfe);
      count(12 * 448);
      chk("ir pulse cycles", e, ih);
      chk("ir idle", 32'h0, {31'h0, irtx});
   endtask : t_ir_tx

   task automatic t_ir_rx(input logic [7:0] prescaler_value, input logic [7:0] c, input int w,
         input logic [7:0] b, input logic e);
      wb(1, 5'h10, {24'h0, prescaler_value});
      wb(1, 5'h0c, {24'h0, c});
      m.ir_send(b, 448, w);
      repeat (60) @(posedge clk);
      wb(0, 5'h00, 0);
      chk("ir byte seen", {31'h0, e}, {31'h0, q[1]});
      wb(0, 5'h04, 0);
      if (e) chk("ir byte", {24'h0, b}, q);
   endtask : t_ir_rx

   task automatic t_half_duplex;
      int n;
      n = 0;
      wb(1, 5'h10, 32'h4);
      wb(1, 5'h0c, 32'h0b);
      wb(1, 5'h04, 32'hff);
      while (tx !== 1'b0 && n < 50) begin
         @(posedge clk);
         n++;
      end
      m.ir_send(8'h00, 448, 84);
      repeat (600) @(posedge clk);
      wb(0, 5'h00, 0);
      chk("rx while tx", 32'h0, {31'h0, q[1]});
      chk("tx complete", 32'h1, {31'h0, q[0]});
   endtask : t_half_duplex

   task automatic t_break;
      wb(1, 5'h08, 32'h1);
      wb(1, 5'h0c, 32'ha7);
      count(300);
      chk("break low cycles", 13 * 16, tl);
      wb(0, 5'h0c, 0);
      chk("break request clears", 32'h87, q);
      wb(0, 5'h00, 0);
      chk("break flag", 32'h1, {31'h0, q[3]});
      chk("framing error", 32'h1, {31'h0, q[2]});
      chk("break irq", 32'h1, {31'h0, irq});
      wb(1, 5'h00, 32'h08);
      repeat (3) @(posedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      wb(0, 5'h04, 0);
   endtask : t_break

   task automatic t_inject(input logic [7:0] c, input int bits, input logic e);
      wb(1, 5'h0c, {24'h0, c});
      m.dominant(bits * 16);
      repeat (64) @(posedge clk);
      wb(0, 5'h00, 0);
      chk("injected break flag", {31'h0, e}, {31'h0, q[3]});
      wb(1, 5'h00, 32'h08);
      wb(0, 5'h04, 0);
   endtask : t_inject

   task automatic wait_st(input int b);
      int n;
      n = 0;
      q = 32'h0;
      while (q[b] !== 1'b1 && n < 400) begin
         wb(0, 5'h00, 0);
         n++;
      end
      chk("status wait", 32'h1, {31'h0, q[b]});
   endtask : wait_st

   task automatic t_header;
      wb(1, 5'h0c, 32'h00);
      wb(0, 5'h04, 0);
      wb(1, 5'h08, 32'h1);
      wb(1, 5'h0c, 32'h04);
      wb(1, 5'h0c, 32'h07);
      wb(1, 5'h0c, 32'h27);
      wait_st(3);
      wb(1, 5'h00, 32'h08);
      wb(0, 5'h04, 0);
      wb(1, 5'h04, 32'h55);
      wait_st(1);
      wb(0, 5'h04, 0);
      chk("sync echo", 32'h55, q);
      wb(1, 5'h04, 32'h92);
      wait_st(1);
      wb(0, 5'h04, 0);
      chk("id echo", 32'h92, q);
      wait_st(0);
      wb(1, 5'h0c, 32'h27);
      wb(1, 5'h04, 32'h55);
      wait_st(0);
      wb(1, 5'h04, 32'h92);
      wait_st(0);
      wb(0, 5'h04, 0);
      chk("header last byte", 32'h92, q);
   endtask : t_header

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_nrz;
      wb(1, 5'h0c, 32'h00);
      t_ir_tx(8'h04, 8'h09, 168);
      t_ir_tx(8'h1e, 8'h19, 180);
      t_ir_tx(8'h00, 8'h09, 0);
      t_ir_rx(8'h04, 8'h0a, 84, 8'h3c, 1'b1);
      t_ir_rx(8'h04, 8'h0a, 7, 8'h00, 1'b0);
      t_ir_rx(8'h04, 8'h0a, 9, 8'h00, 1'b1);
      t_ir_rx(8'h00, 8'h0a, 84, 8'h00, 1'b0);
      t_ir_rx(8'h1e, 8'h1a, 62, 8'h5a, 1'b1);
      t_ir_rx(8'h1e, 8'h1a, 29, 8'h00, 1'b0);
      t_half_duplex;
      t_break;
      t_inject(8'h47, 10, 1'b0);
      t_inject(8'h07, 10, 1'b1);
      t_inject(8'h07, 9, 1'b0);
      t_inject(8'h03, 10, 1'b0);
      t_header;
      final_report;
   end

   initial begin
      repeat (90000) @(posedge clk);
      err_count++;
      final_report;
   end
endmodule : uil_top_tb
